//--- hdl/nvac_pkg.sv
/*
  Package for the data nonvolatile access control block: register indices,
  control bit positions, reset values, unlock codes, timer constants.
  Assumes a processor core that reaches the registers by a simple
  special-function-register port, one byte per access, on mclk.
*/
// What this block does
// - Space select bit set routes to program flash, clear to data store.
// - Config space select set targets configuration registers instead.
// - Eight-bit address picks one of 256 bytes, 00h to FFh.
// - Data register carries the one byte read or written.
// - Each byte write erases the location first, then programs it.
// - Write length set by internal programming timer expiry.
// - Write permit comes out of reset cleared.
// - Write permit clear blocks every write and erase cycle.
// - Abort flag set with write start, cleared when timer completes.
// - Interrupted or improper write keeps abort flag and space selects.
// - Write start settable only by firmware, cleared by hardware.
// - Completion sets write-done flag; only firmware clears it.
// - Read start reads in one cycle then self-clears.
// - Read start ignored when either space select bit is one.
// - Unlock port stores nothing and reads zero.
// - Row erase bit makes next write erase a flash row, then clears.
// - Control bit 5 reads zero always.
// - Write needs 55h then 0AAh to unlock port, then write start.
// - Write start needs permit already set, not in the same write.
// - Control, address and data locked while a write runs.
package nvac_pkg;

  // Register indices on the core port
  localparam logic [3:0] REG_NV_CONTROL   = 4'h0;
  localparam logic [3:0] REG_UNLOCK_PORT  = 4'h1;
  localparam logic [3:0] REG_NV_DATA      = 4'h2;
  localparam logic [3:0] REG_NV_ADDRESS   = 4'h3;
  localparam logic [3:0] REG_IRQ_FLAGS_2  = 4'h4;
  localparam logic [3:0] REG_IRQ_ENABLE_2 = 4'h5;
  localparam logic [3:0] REG_IRQ_PRIO_2   = 4'h6;
  localparam logic [3:0] REG_TBL_UPPER    = 4'h7;
  localparam logic [3:0] REG_TBL_HIGH     = 4'h8;
  localparam logic [3:0] REG_TBL_LOW      = 4'h9;

  // Control and interrupt flag bit positions
  localparam int BIT_MEM_SPACE  = 7;
  localparam int BIT_CFG_SPACE  = 6;
  localparam int BIT_ROW_ERASE  = 4;
  localparam int BIT_ABORT      = 3;
  localparam int BIT_PERMIT     = 2;
  localparam int BIT_WR_START   = 1;
  localparam int BIT_RD_START   = 0;
  localparam int BIT_WRITE_DONE = 4;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] TBL_UPPER_MASK = 8'h3F;

  // Programming time, nominal; timer counts mclk cycles
  localparam int CLK_MHZ      = 200;
  localparam int PROG_TIME_US = 4000;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int TIMER_W      = 24;

  typedef enum logic [1:0] {
    NVAC_IDLE   = 2'b00,
    NVAC_ERASE  = 2'b01,
    NVAC_WRITE  = 2'b10
  } nvac_state_type;

  typedef enum logic [1:0] {
    NVAC_TGT_DATA  = 2'b00,
    NVAC_TGT_FLASH = 2'b01,
    NVAC_TGT_CFG   = 2'b10
  } nvac_target_type;

  // Request to the storage array
  typedef struct packed {
    logic            rd;
    logic            erase;
    logic            prog;
    logic            row_erase;
    nvac_target_type target;
    logic [7:0]      addr;
    logic [7:0]      data;
  } nvac_mem_req_type;

endpackage

//--- hdl/nvac_prog_timer.sv
/*
  Programming timer: counts a load value down and pulses on expiry.
  Assumes start is a one-cycle pulse from the control logic on mclk.
*/
`timescale 1ns/1ps
module nvac_prog_timer (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  // Control
  input  wire logic                       start,
  input  wire logic [nvac_pkg::TIMER_W-1:0] load,
  output logic                            expired
);
  logic [nvac_pkg::TIMER_W-1:0] count;
  logic                         running;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (clk_en) begin
      expired <= 1'b0;
      if (start) begin
        count   <= load;
        running <= 1'b1;
      end else if (running) begin
        if (count <= 1) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule

//--- hdl/nvac_top.sv
/*
  Access control for the on-chip data store and program flash: control,
  unlock, address, data and flag registers, unlock sequence and the
  self-timed erase/program cycle.
  Assumes a core-side byte port on mclk with one-cycle write strobes and a
  storage array that returns read data combinationally for the address.
*/
`timescale 1ns/1ps
module nvac_top #(
  parameter int PROG_CYCLES = nvac_pkg::PROG_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      clk_en,
  // Core register port
  input  wire logic [3:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata,
  // Storage array
  output nvac_pkg::nvac_mem_req_type     mem_req,
  input  wire logic [7:0]                mem_rdata,
  // Status to the core
  output logic                           write_busy,
  output logic                           write_done_irq
);
  logic       mem_space_select;
  logic       config_space_select;
  logic       row_erase;
  logic       write_abort_flag;
  logic       write_permit;
  logic       write_start;
  logic       read_start;
  logic [7:0] nv_data;
  logic [7:0] nv_address;
  logic [7:0] table_pointer_upper;
  logic [7:0] table_pointer_high;
  logic [7:0] table_pointer_low;
  logic       write_done_flag;
  logic       write_done_irq_enable;
  logic       write_done_irq_priority;
  logic [1:0] unlock_step;
  logic       timer_start;
  logic       timer_expired;
  logic       launch;
  logic       read_go;
  nvac_pkg::nvac_state_type state;
  nvac_pkg::nvac_state_type next_state;

  function automatic logic wr_hit(input logic [3:0] idx);
    return reg_wr && (reg_addr == idx);
  endfunction

  function automatic nvac_pkg::nvac_target_type pick_target(
    input logic mem_sel,
    input logic cfg_sel
  );
    if (cfg_sel) begin
      return nvac_pkg::NVAC_TGT_CFG;
    end
    return mem_sel ? nvac_pkg::NVAC_TGT_FLASH
                   : nvac_pkg::NVAC_TGT_DATA;
  endfunction

  localparam logic [nvac_pkg::TIMER_W-1:0] TIMER_LOAD =
    nvac_pkg::TIMER_W'(PROG_CYCLES);

  // Launch only with permit already held and full unlock done
  assign launch = wr_hit(nvac_pkg::REG_NV_CONTROL)
                  && reg_wdata[nvac_pkg::BIT_WR_START]
                  && write_permit
                  && (unlock_step == 2'd2)
                  && (state == nvac_pkg::NVAC_IDLE);

  // Read start refused when pointing away from data store
  assign read_go = wr_hit(nvac_pkg::REG_NV_CONTROL)
                   && reg_wdata[nvac_pkg::BIT_RD_START]
                   && !mem_space_select
                   && !config_space_select
                   && !reg_wdata[nvac_pkg::BIT_MEM_SPACE]
                   && !reg_wdata[nvac_pkg::BIT_CFG_SPACE]
                   && (state == nvac_pkg::NVAC_IDLE);

  assign write_busy = write_start;

  // Unlock sequence tracker; any other write to the port or control breaks it
  always_ff @(posedge mclk) begin
    if (srst) begin
      unlock_step <= 2'd0;
    end else if (clk_en) begin
      if (wr_hit(nvac_pkg::REG_UNLOCK_PORT)) begin
        if (reg_wdata == nvac_pkg::UNLOCK_KEY1) begin
          unlock_step <= 2'd1;
        end else if (reg_wdata == nvac_pkg::UNLOCK_KEY2
                     && unlock_step == 2'd1) begin
          unlock_step <= 2'd2;
        end else begin
          unlock_step <= 2'd0;
        end
      end else if (wr_hit(nvac_pkg::REG_NV_CONTROL)) begin
        unlock_step <= 2'd0;
      end
    end
  end

  // Erase then program, or erase alone when row erase is set, each phase timed by the programming timer
  always_comb begin
    next_state  = state;
    timer_start = 1'b0;
    unique case (state)
      nvac_pkg::NVAC_IDLE: begin
        if (launch) begin
          next_state  = nvac_pkg::NVAC_ERASE;
          timer_start = 1'b1;
        end
      end
      nvac_pkg::NVAC_ERASE: begin
        if (timer_expired) begin
          if (row_erase) begin
            next_state = nvac_pkg::NVAC_IDLE;
          end else begin
            next_state  = nvac_pkg::NVAC_WRITE;
            timer_start = 1'b1;
          end
        end
      end
      nvac_pkg::NVAC_WRITE: begin
        if (timer_expired) begin
          next_state = nvac_pkg::NVAC_IDLE;
        end
      end
      default: next_state = nvac_pkg::NVAC_IDLE;
    endcase
  end

  logic op_done;
  assign op_done = timer_expired && (state != nvac_pkg::NVAC_IDLE)
                   && (next_state == nvac_pkg::NVAC_IDLE);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= nvac_pkg::NVAC_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  nvac_prog_timer u_timer (
    .mclk    (mclk),
    .srst    (srst),
    .clk_en  (clk_en),
    .start   (timer_start),
    .load    (TIMER_LOAD),
    .expired (timer_expired)
  );

  // Space selects have no reset, so a cut write can still be traced
  always_ff @(posedge mclk) begin
    if (clk_en && !srst) begin
      if (wr_hit(nvac_pkg::REG_NV_CONTROL) && !write_start) begin
        mem_space_select    <= reg_wdata[nvac_pkg::BIT_MEM_SPACE];
        config_space_select <= reg_wdata[nvac_pkg::BIT_CFG_SPACE];
      end
    end
  end

  // Row erase; frozen during a write
  always_ff @(posedge mclk) begin
    if (srst) begin
      row_erase <= 1'b0;
    end else if (clk_en) begin
      if (op_done) begin
        row_erase <= 1'b0;
      end else if (wr_hit(nvac_pkg::REG_NV_CONTROL) && !write_start) begin
        row_erase <= reg_wdata[nvac_pkg::BIT_ROW_ERASE];
      end
    end
  end

  // Permit cleared at reset; abort flag survives reset for tracing
  always_ff @(posedge mclk) begin
    if (srst) begin
      write_permit <= 1'b0;
    end else if (clk_en) begin
      if (wr_hit(nvac_pkg::REG_NV_CONTROL) && !write_start) begin
        write_permit <= reg_wdata[nvac_pkg::BIT_PERMIT];
      end
    end
  end

  // Abort flag has no reset: a reset mid-write must leave it high
  always_ff @(posedge mclk) begin
    if (clk_en && !srst) begin
      if (launch) begin
        write_abort_flag <= 1'b1;
      end else if (op_done) begin
        write_abort_flag <= 1'b0;
      end else if (wr_hit(nvac_pkg::REG_NV_CONTROL) && !write_start) begin
        write_abort_flag <= reg_wdata[nvac_pkg::BIT_ABORT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      write_start <= 1'b0;
      read_start  <= 1'b0;
    end else if (clk_en) begin
      if (launch) begin
        write_start <= 1'b1;
      end else if (op_done) begin
        write_start <= 1'b0;
      end
      read_start <= read_go;
    end
  end

  // Address and data; read result loads the data register
  always_ff @(posedge mclk) begin
    if (srst) begin
      nv_data    <= nvac_pkg::RESET_BYTE;
      nv_address <= nvac_pkg::RESET_BYTE;
    end else if (clk_en) begin
      if (read_start) begin
        nv_data <= mem_rdata;
      end else if (wr_hit(nvac_pkg::REG_NV_DATA) && !write_start) begin
        nv_data <= reg_wdata;
      end
      if (wr_hit(nvac_pkg::REG_NV_ADDRESS) && !write_start) begin
        nv_address <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      table_pointer_upper <= nvac_pkg::RESET_BYTE;
      table_pointer_high  <= nvac_pkg::RESET_BYTE;
      table_pointer_low   <= nvac_pkg::RESET_BYTE;
    end else if (clk_en && !write_start) begin
      if (wr_hit(nvac_pkg::REG_TBL_UPPER)) begin
        table_pointer_upper <= reg_wdata & nvac_pkg::TBL_UPPER_MASK;
      end
      if (wr_hit(nvac_pkg::REG_TBL_HIGH)) begin
        table_pointer_high <= reg_wdata;
      end
      if (wr_hit(nvac_pkg::REG_TBL_LOW)) begin
        table_pointer_low <= reg_wdata;
      end
    end
  end

  // Done flag: hardware set wins over a firmware clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      write_done_flag         <= 1'b0;
      write_done_irq_enable   <= 1'b0;
      write_done_irq_priority <= 1'b1;
    end else if (clk_en) begin
      if (op_done) begin
        write_done_flag <= 1'b1;
      end else if (wr_hit(nvac_pkg::REG_IRQ_FLAGS_2)) begin
        write_done_flag <= reg_wdata[nvac_pkg::BIT_WRITE_DONE];
      end
      if (wr_hit(nvac_pkg::REG_IRQ_ENABLE_2)) begin
        write_done_irq_enable <= reg_wdata[nvac_pkg::BIT_WRITE_DONE];
      end
      if (wr_hit(nvac_pkg::REG_IRQ_PRIO_2)) begin
        write_done_irq_priority <= reg_wdata[nvac_pkg::BIT_WRITE_DONE];
      end
    end
  end

  assign write_done_irq = write_done_flag && write_done_irq_enable;

  // Array request; erase phase covers a flash row when row erase is set
  always_comb begin
    mem_req           = '0;
    mem_req.rd        = read_start;
    mem_req.erase     = (state == nvac_pkg::NVAC_ERASE);
    mem_req.prog      = (state == nvac_pkg::NVAC_WRITE);
    mem_req.row_erase = row_erase;
    mem_req.target    = pick_target(mem_space_select, config_space_select);
    mem_req.addr      = nv_address;
    mem_req.data      = nv_data;
  end

  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      nvac_pkg::REG_NV_CONTROL:
        reg_rdata = {mem_space_select, config_space_select,
                     1'b0,
                     row_erase, write_abort_flag, write_permit,
                     write_start, read_start};
      nvac_pkg::REG_UNLOCK_PORT:  reg_rdata = 8'h00;
      nvac_pkg::REG_NV_DATA:      reg_rdata = nv_data;
      nvac_pkg::REG_NV_ADDRESS:   reg_rdata = nv_address;
      nvac_pkg::REG_IRQ_FLAGS_2:  reg_rdata = {3'b000, write_done_flag, 4'h0};
      nvac_pkg::REG_IRQ_ENABLE_2:
        reg_rdata = {3'b000, write_done_irq_enable, 4'h0};
      nvac_pkg::REG_IRQ_PRIO_2:
        reg_rdata = {3'b000, write_done_irq_priority, 4'h0};
      nvac_pkg::REG_TBL_UPPER:    reg_rdata = table_pointer_upper;
      nvac_pkg::REG_TBL_HIGH:     reg_rdata = table_pointer_high;
      nvac_pkg::REG_TBL_LOW:      reg_rdata = table_pointer_low;
      default:                    reg_rdata = 8'h00;
    endcase
  end
endmodule

//--- verification/nvac_checker_assertions.sv
/*
  Checker for nvac_top: watches the top-level ports only.
  Assumes one clock domain, srst synchronous active high.
*/
`timescale 1ns/1ps
module nvac_checker #(
  parameter int PROG_CYCLES = 8
) (
  // Clock, reset, enable
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic                       clk_en,
  // Core register port
  input wire logic [3:0]                 reg_addr,
  input wire logic                       reg_wr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic [7:0]                 reg_rdata,
  // Storage array and status
  input wire nvac_pkg::nvac_mem_req_type mem_req,
  input wire logic [7:0]                 mem_rdata,
  input wire logic                       write_busy,
  input wire logic                       write_done_irq
);
  localparam int ONE_PH = PROG_CYCLES + 1;
  localparam int TWO_PH = 2 * ONE_PH;
  logic irq_en;
  int   busy_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Shadow of the enable bit, so the irq output can be judged
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == 4'h5) begin
      irq_en <= reg_wdata[nvac_pkg::BIT_WRITE_DONE];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst || !write_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  a_rd_one_cycle: assert property (
    mem_req.rd |=> !mem_req.rd)
    else $error("read strobe longer than one cycle");
  a_rd_data_only: assert property (
    mem_req.rd |-> mem_req.target == nvac_pkg::NVAC_TGT_DATA)
    else $error("read strobe outside data space");
  a_erase_first: assert property (
    $rose(write_busy) |-> mem_req.erase && !mem_req.prog)
    else $error("write did not start with erase");
  a_start_source: assert property (
    $rose(write_busy) |-> $past(reg_wr)
      && $past(reg_addr) == nvac_pkg::REG_NV_CONTROL
      && $past(reg_wdata[nvac_pkg::BIT_WR_START]))
    else $error("write started without a control write");
  a_timed_length: assert property (
    $fell(write_busy) |-> busy_cnt == TWO_PH || busy_cnt == ONE_PH)
    else $error("write length differs from timer");
  a_done_with_end: assert property (
    $fell(write_busy) |-> write_done_irq == irq_en)
    else $error("done flag not set at write end");
  a_done_sticky: assert property (
    write_done_irq && !(reg_wr && (reg_addr == 4'h4 || reg_addr == 4'h5))
    |=> write_done_irq)
    else $error("done flag cleared by hardware");
  a_addr_locked: assert property (
    write_busy && reg_wr && reg_addr == nvac_pkg::REG_NV_ADDRESS
    |=> $stable(mem_req.addr))
    else $error("address changed during write");
  a_idle_no_cycle: assert property (
    !write_busy |-> !(mem_req.erase || mem_req.prog))
    else $error("erase or program while idle");
  a_unlock_zero: assert property (
    reg_addr == nvac_pkg::REG_UNLOCK_PORT |-> reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  a_bit5_zero: assert property (
    reg_addr == nvac_pkg::REG_NV_CONTROL |-> !reg_rdata[5])
    else $error("control bit 5 read as one");
endmodule
bind nvac_top nvac_checker #(.PROG_CYCLES(PROG_CYCLES)) i_checker (
  .mclk(mclk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_rdata(mem_rdata), .write_busy(write_busy),
  .write_done_irq(write_done_irq));

//--- verification/nvac_store_model.sv
/*
  Behavioural storage array behind nvac_top: 256 data bytes.
  Assumes erase and program phases are levels on mem_req.
*/
`timescale 1ns/1ps
module nvac_store_model (
  // Clock
  input  wire logic                       mclk,
  // Request and read data
  input  wire nvac_pkg::nvac_mem_req_type mem_req,
  output logic [7:0]                      mem_rdata
);
  logic [7:0] mem [256];
  logic       data_tgt;
  assign data_tgt = mem_req.target == nvac_pkg::NVAC_TGT_DATA;
  // Outside a read strobe the bus carries junk, never stale data
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~mem[mem_req.addr];
  always @(posedge mclk) begin
    if (data_tgt && mem_req.erase) begin
      mem[mem_req.addr] <= 8'hFF;
    end
    if (data_tgt && mem_req.prog) begin
      mem[mem_req.addr] <= mem_req.data;
    end
  end
endmodule

//--- verification/data_eeprom_access_control_tb.sv
/*
  Self-checking bench for nvac_top with the storage model.
  Assumes PROG_CYCLES shortened to 8; inputs change on falling edges.
*/
`timescale 1ns/1ps
module data_eeprom_access_control_tb;
  localparam logic [3:0] CTL = nvac_pkg::REG_NV_CONTROL;
  localparam logic [3:0] ULK = nvac_pkg::REG_UNLOCK_PORT;
  localparam logic [3:0] DAT = nvac_pkg::REG_NV_DATA;
  localparam logic [3:0] ADR = nvac_pkg::REG_NV_ADDRESS;
  localparam logic [3:0] FLG = nvac_pkg::REG_IRQ_FLAGS_2;
  localparam logic [3:0] IEN = nvac_pkg::REG_IRQ_ENABLE_2;
  logic                       mclk = 1'b0;
  logic                       srst = 1'b1;
  logic                       clk_en = 1'b1;
  logic [3:0]                 reg_addr = 4'h0;
  logic                       reg_wr = 1'b0;
  logic [7:0]                 reg_wdata = 8'h00;
  logic [7:0]                 reg_rdata;
  nvac_pkg::nvac_mem_req_type mem_req;
  logic [7:0]                 mem_rdata;
  logic                       write_busy;
  logic                       write_done_irq;
  int                         fail_count = 0;
  int                         check_count = 0;
  int                         cycles = 0;
  always #2.5 mclk = ~mclk;
  nvac_top #(.PROG_CYCLES(8)) i_dut (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .write_busy(write_busy),
    .write_done_irq(write_done_irq));
  nvac_store_model i_store (
    .mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    #1 d = reg_rdata;
  endtask
  task automatic unlock;
    wr(ULK, 8'h55);
    wr(ULK, 8'hAA);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("busy_end", 8'h00, {7'h0, write_busy});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] v;
    rd(CTL, v);
    chk("permit", 8'h00, {5'h0, v[2], 2'h0});
    wr(ULK, 8'h55);
    rd(ULK, v);
    chk("unlock_rd", 8'h00, v);
    wr(CTL, 8'hFF);
    rd(CTL, v);
    chk("ctl_ff", 8'hDC, v);
    chk("busy_ff", 8'h00, {7'h0, write_busy});
    wr(CTL, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_write;
    logic [7:0] v;
    wr(IEN, 8'h10);
    wr(ADR, 8'hFF);
    wr(DAT, 8'h3C);
    wr(CTL, 8'h04);
    unlock();
    wr(CTL, 8'h06);
    rd(CTL, v);
    chk("abort_set", 8'h0E, v);
    wr(ADR, 8'h11);
    wr(CTL, 8'h00);
    chk("addr_lock", 8'hFF, mem_req.addr);
    chk("no_clear", 8'h01, {7'h0, write_busy});
    wait_idle();
    chk("done_irq", 8'h01, {7'h0, write_done_irq});
    rd(CTL, v);
    chk("ctl_done", 8'h04, v);
    chk("stored", 8'h3C, i_store.mem[8'hFF]);
    wr(FLG, 8'h00);
    chk("done_clr", 8'h00, {7'h0, write_done_irq});
    $display("test write done");
  endtask
  task automatic t_read;
    logic [7:0] v;
    i_store.mem[8'h00] = 8'h5A;
    wr(ADR, 8'h00);
    wr(CTL, 8'h01);
    rd(DAT, v);
    chk("rd_low", 8'h5A, v);
    rd(CTL, v);
    chk("rd_clear", 8'h00, v);
    wr(ADR, 8'hFF);
    wr(CTL, 8'h01);
    rd(DAT, v);
    chk("rd_high", 8'h3C, v);
    @(negedge mclk);
    clk_en = 1'b0;
    wr(ADR, 8'h77);
    clk_en = 1'b1;
    rd(ADR, v);
    chk("addr_frozen", 8'hFF, v);
    $display("test read done");
  endtask
  task automatic t_refuse;
    wr(CTL, 8'h04);
    wr(ULK, 8'h55);
    wr(ULK, 8'h12);
    wr(ULK, 8'hAA);
    wr(CTL, 8'h06);
    @(negedge mclk);
    chk("bad_seq", 8'h00, {7'h0, write_busy});
    wr(CTL, 8'h00);
    unlock();
    wr(CTL, 8'h06);
    @(negedge mclk);
    chk("no_permit", 8'h00, {7'h0, write_busy});
    $display("test refuse done");
  endtask
  task automatic t_flash;
    logic [7:0] v;
    wr(CTL, 8'h94);
    unlock();
    wr(CTL, 8'h96);
    chk("flash_tgt", 8'h01, {6'h0, mem_req.target});
    chk("row_busy", 8'h01, {7'h0, write_busy});
    wait_idle();
    rd(CTL, v);
    chk("row_clr", 8'h84, v);
    wr(CTL, 8'h45);
    chk("cfg_tgt", 8'h02, {6'h0, mem_req.target});
    rd(CTL, v);
    chk("cfg_rd", 8'h44, v);
    wr(FLG, 8'h00);
    $display("test flash done");
  endtask
  task automatic t_abort;
    logic [7:0] v;
    wr(CTL, 8'h84);
    unlock();
    wr(CTL, 8'h86);
    @(negedge mclk);
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    rd(CTL, v);
    chk("abort_kept", 8'h88, {v[7], 3'h0, v[3], 3'h0});
    $display("test abort done");
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    t_reset();
    t_write();
    t_read();
    t_refuse();
    t_flash();
    t_abort();
    final_report();
  end
endmodule
